// >>> inc/ldrr_pkg.sv
// constants and types for the logical device resource routing block
package ldrr_pkg;
  // apb register byte offsets
  localparam logic [7:0] LDRR_ACT_OFS   = 8'h00;
  localparam logic [7:0] LDRR_PWR_OFS   = 8'h04;
  localparam logic [7:0] LDRR_LDN_OFS   = 8'h08;
  localparam logic [7:0] LDRR_TASK_OFS  = 8'h10;
  localparam logic [7:0] LDRR_MISC_OFS  = 8'h14;
  localparam logic [7:0] LDRR_GRD_OFS   = 8'h18;
  localparam logic [7:0] LDRR_GWR_OFS   = 8'h1c;
  localparam logic [7:0] LDRR_TWB_OFS   = 8'h20;
  localparam logic [7:0] LDRR_PAIR_OFS  = 8'h24;
  localparam logic [7:0] LDRR_GATE_OFS  = 8'h28;
  localparam logic [7:0] LDRR_UART_OFS  = 8'h2c;
  localparam logic [7:0] LDRR_STAT_OFS  = 8'h30;
  localparam logic [7:0] LDRR_IRQ_OFS   = 8'h70;
  localparam logic [7:0] LDRR_DMA_OFS   = 8'h74;
  // reset values
  localparam logic [7:0]  LDRR_IRQ_RST  = 8'h00;
  localparam logic [7:0]  LDRR_DMA_RST  = 8'h04;
  localparam logic [11:0] LDRR_BASE_RST = 12'h000;
  // activate bit positions
  localparam int LDRR_A_FDC  = 0;
  localparam int LDRR_A_DISK = 1;
  localparam int LDRR_A_PP   = 2;
  localparam int LDRR_A_U1   = 3;
  localparam int LDRR_A_U2   = 4;
  localparam int LDRR_A_KBD  = 5;
  localparam int LDRR_A_AUX  = 6;
  localparam int LDRR_A_TWB  = 7;
  localparam int LDRR_A_PAIR = 8;
  localparam int LDRR_NACT   = 9;
  // routed device numbers behind the select register
  localparam logic [1:0] LDRR_D_FDC = 2'h0;
  localparam logic [1:0] LDRR_D_PP  = 2'h1;
  localparam logic [1:0] LDRR_D_U1  = 2'h2;
  localparam logic [1:0] LDRR_D_U2  = 2'h3;
  // gate register fields
  localparam int LDRR_G_FDMA = 0;
  localparam int LDRR_G_FPD  = 1;
  localparam int LDRR_G_PIRQ = 2;
  localparam int LDRR_G_PMOD = 3;
  localparam int LDRR_G_ECR  = 5;
  localparam int LDRR_G_SVC  = 8;
  localparam int LDRR_G_EDMA = 9;
  localparam int LDRR_G_W    = 10;
  // uart gate register fields
  localparam int LDRR_U1_IEN = 0;
  localparam int LDRR_U1_OUT = 4;
  localparam int LDRR_U2_IEN = 8;
  localparam int LDRR_U2_OUT = 12;
  localparam int LDRR_U2_DMA = 13;
  localparam int LDRR_U_W    = 14;
  // fixed keyboard ports and ranges
  localparam logic [11:0] LDRR_KBD_DATA = 12'h060;
  localparam logic [11:0] LDRR_KBD_CMD  = 12'h064;
  localparam logic [11:0] LDRR_TASK_MIN = 12'h100;
  localparam logic [11:0] LDRR_TASK_MAX = 12'hff8;
  localparam logic [11:0] LDRR_MISC_MIN = 12'h100;
  localparam logic [11:0] LDRR_PAIR_MIN = 12'h100;
  localparam logic [11:0] LDRR_PAIR_MAX = 12'hffe;
  localparam logic [11:0] LDRR_TWB_MAX  = 12'hffc;
  // ecr modes where the parallel interrupt stays on
  localparam logic [2:0] LDRR_ECR_FIFO = 3'h2;
  localparam logic [2:0] LDRR_ECR_ECP  = 3'h3;
  localparam logic [2:0] LDRR_ECR_TEST = 3'h6;
  typedef enum logic [1:0] {LDRR_PP_SPP, LDRR_PP_EPP, LDRR_PP_ECP} ldrr_pp_mode_t;
  // per device interrupt level and dma channel
  typedef struct packed {
    logic [7:0] irq;
    logic [7:0] dma;
  } ldrr_route_t;
  // isa cycle as seen by the decoder
  typedef struct packed {
    logic [15:0] addr;
    logic        aen;
    logic        ior_n;
    logic        iow_n;
  } ldrr_isa_t;
endpackage

// >>> logic/ldrr_top.sv
// resource routing: base decode, interrupt and dma routing, apb registers
`timescale 1ns/1ps
module ldrr_top
  import ldrr_pkg::*;
#(
  parameter int NIRQ = 16,
  parameter int NDMA = 4
) (
  input  wire logic              SYS_CLK,
  input  wire logic              SRST,
  input  wire logic [7:0]        PADDR,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire ldrr_isa_t         ISA,
  input  wire logic              FDC_IRQ,
  input  wire logic              PP_IRQ,
  input  wire logic              U1_IRQ,
  input  wire logic              U2_IRQ,
  input  wire logic              FDC_DRQ,
  input  wire logic              PP_DRQ,
  input  wire logic              U2_DRQ,
  input  wire logic [NDMA-1:0]   ISA_DACK_N,
  output logic      [NIRQ-1:0]   IRQ_OUT,
  output logic      [NIRQ-1:0]   IRQ_OE,
  output logic      [NDMA-1:0]   DRQ_OUT,
  output logic      [NDMA-1:0]   DRQ_OE,
  output logic                   FDC_DACK,
  output logic                   PP_DACK,
  output logic                   U2_DACK,
  output logic                   KBD_DATA_SEL,
  output logic                   KBD_CMD_SEL,
  output logic                   GEN_RD_SEL,
  output logic                   GEN_WR_SEL,
  output logic                   TWB_SEL,
  output logic      [1:0]        TWB_REG,
  output logic                   PAIR_INDEX_SEL,
  output logic                   PAIR_DATA_SEL,
  output logic                   DISK_TASK_SELECT_N,
  output logic      [2:0]        DISK_TASK_REG,
  output logic                   DISK_AUX_SELECT_N
);

  // elaboration check: the pin maps below assume these widths
  if (NIRQ != 16 || NDMA != 4) begin : g_width_chk
    $error("ldrr_top serves 16 irq and 4 dma lines only");
  end

  logic [LDRR_NACT-1:0] act_reg;
  logic [1:0]           ldn_reg;
  logic [11:0]          task_reg;
  logic [11:0]          misc_reg;
  logic [11:0]          grd_reg;
  logic [11:0]          gwr_reg;
  logic [11:0]          twb_reg;
  logic [11:0]          pair_reg;
  logic [LDRR_G_W-1:0]  gate_reg;
  logic [LDRR_U_W-1:0]  uart_reg;
  ldrr_route_t          route_reg [4];
  logic                 acc;
  logic                 wr;
  logic                 hit;
  logic [31:0]          rd_next;

  // apb phases: access answered one cycle after it begins
  assign acc = PSEL && PENABLE && !PREADY;
  assign wr  = PSEL && PENABLE && PREADY && PWRITE;

  // register write side
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      act_reg  <= '0;
      ldn_reg  <= LDRR_D_FDC;
      task_reg <= LDRR_BASE_RST;
      misc_reg <= LDRR_BASE_RST;
      grd_reg  <= LDRR_BASE_RST;
      gwr_reg  <= LDRR_BASE_RST;
      twb_reg  <= LDRR_BASE_RST;
      pair_reg <= LDRR_BASE_RST;
      gate_reg <= '0;
      uart_reg <= '0;
      for (int i = 0; i < 4; i++) begin
        route_reg[i] <= '{irq: LDRR_IRQ_RST, dma: LDRR_DMA_RST};
      end
    end else if (wr) begin
      case (PADDR)
        LDRR_ACT_OFS, LDRR_PWR_OFS: act_reg <= PWDATA[LDRR_NACT-1:0];
        LDRR_LDN_OFS:  ldn_reg  <= PWDATA[1:0];
        LDRR_TASK_OFS: task_reg <= PWDATA[11:0];
        LDRR_MISC_OFS: misc_reg <= PWDATA[11:0];
        LDRR_GRD_OFS:  grd_reg  <= PWDATA[11:0];
        LDRR_GWR_OFS:  gwr_reg  <= PWDATA[11:0];
        LDRR_TWB_OFS:  twb_reg  <= PWDATA[11:0];
        LDRR_PAIR_OFS: pair_reg <= PWDATA[11:0];
        LDRR_GATE_OFS: gate_reg <= PWDATA[LDRR_G_W-1:0];
        LDRR_UART_OFS: uart_reg <= PWDATA[LDRR_U_W-1:0];
        LDRR_IRQ_OFS:  route_reg[ldn_reg].irq <= PWDATA[7:0];
        LDRR_DMA_OFS:  route_reg[ldn_reg].dma <= PWDATA[7:0];
        default: ;
      endcase
    end
  end

  // read mux and address map check
  always_comb begin
    rd_next = '0;
    hit     = 1'b1;
    case (PADDR)
      LDRR_ACT_OFS, LDRR_PWR_OFS: rd_next[LDRR_NACT-1:0] = act_reg;
      LDRR_LDN_OFS:  rd_next[1:0]  = ldn_reg;
      LDRR_TASK_OFS: rd_next[11:0] = task_reg;
      LDRR_MISC_OFS: rd_next[11:0] = misc_reg;
      LDRR_GRD_OFS:  rd_next[11:0] = grd_reg;
      LDRR_GWR_OFS:  rd_next[11:0] = gwr_reg;
      LDRR_TWB_OFS:  rd_next[11:0] = twb_reg;
      LDRR_PAIR_OFS: rd_next[11:0] = pair_reg;
      LDRR_GATE_OFS: rd_next[LDRR_G_W-1:0] = gate_reg;
      LDRR_UART_OFS: rd_next[LDRR_U_W-1:0] = uart_reg;
      LDRR_STAT_OFS: rd_next = {8'h00, DRQ_OE, 4'h0, IRQ_OE};
      LDRR_IRQ_OFS:  rd_next[7:0] = route_reg[ldn_reg].irq;
      LDRR_DMA_OFS:  rd_next[7:0] = route_reg[ldn_reg].dma;
      default:       hit = 1'b0;
    endcase
  end

  // apb answer flops
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= acc;
      PSLVERR <= acc && !hit;
      if (acc && !PWRITE) begin
        PRDATA <= rd_next;
      end
    end
  end

  // gate bits of the routed devices
  ldrr_pp_mode_t pp_mode;
  logic [2:0]    ecr_mode;
  logic          fdc_gate;
  logic          pp_irq_gate;
  logic          pp_dma_gate;
  logic          u1_irq_gate;
  logic          u2_irq_gate;
  logic          u2_dma_gate;
  logic          pp_irq_lvl;
  logic          pp_ecp;

  assign pp_mode  = ldrr_pp_mode_t'(gate_reg[LDRR_G_PMOD +: 2]);
  assign ecr_mode = gate_reg[LDRR_G_ECR +: 3];
  assign pp_ecp   = (pp_mode == LDRR_PP_ECP);
  // floppy lines live only with dma gate set and not powered down
  assign fdc_gate = act_reg[LDRR_A_FDC] && gate_reg[LDRR_G_FDMA]
                    && !gate_reg[LDRR_G_FPD];

  // parallel interrupt gate by mode
  always_comb begin
    pp_irq_gate = 1'b0;
    case (pp_mode)
      LDRR_PP_SPP, LDRR_PP_EPP: pp_irq_gate = gate_reg[LDRR_G_PIRQ];
      LDRR_PP_ECP: begin
        if (ecr_mode == LDRR_ECR_FIFO || ecr_mode == LDRR_ECR_ECP
            || ecr_mode == LDRR_ECR_TEST) begin
          pp_irq_gate = !gate_reg[LDRR_G_SVC];
        end else begin
          pp_irq_gate = gate_reg[LDRR_G_PIRQ] && !gate_reg[LDRR_G_SVC];
        end
      end
      default: pp_irq_gate = 1'b0;
    endcase
  end

  assign pp_dma_gate = pp_ecp && gate_reg[LDRR_G_EDMA];
  // uart needs some enable bit and its aux output b
  assign u1_irq_gate = (|uart_reg[LDRR_U1_IEN +: 4]) && uart_reg[LDRR_U1_OUT];
  assign u2_irq_gate = (|uart_reg[LDRR_U2_IEN +: 4]) && uart_reg[LDRR_U2_OUT];
  assign u2_dma_gate = uart_reg[LDRR_U2_DMA];
  // parallel ecp/epp interrupt is an active low level
  assign pp_irq_lvl  = (pp_mode == LDRR_PP_SPP) ? PP_IRQ : !PP_IRQ;

  // per device interrupt enable, level and value
  logic [3:0] irq_en;
  logic [3:0] irq_val;
  logic [3:0] irq_lvl [4];
  always_comb begin
    for (int d = 0; d < 4; d++) begin
      irq_lvl[d] = route_reg[d].irq[3:0];
    end
    irq_en[LDRR_D_FDC] = fdc_gate;
    irq_en[LDRR_D_PP]  = act_reg[LDRR_A_PP] && pp_irq_gate;
    irq_en[LDRR_D_U1]  = act_reg[LDRR_A_U1] && u1_irq_gate;
    irq_en[LDRR_D_U2]  = act_reg[LDRR_A_U2] && u2_irq_gate;
    irq_val = {U2_IRQ, U1_IRQ, pp_irq_lvl, FDC_IRQ};
  end

  // pin drive: level zero drives nothing, unused pins float
  logic [NIRQ-1:0] irq_oe_next;
  logic [NIRQ-1:0] irq_out_next;
  always_comb begin
    irq_oe_next  = '0;
    irq_out_next = '0;
    for (int d = 0; d < 4; d++) begin
      if (irq_en[d] && irq_lvl[d] != 4'h0) begin
        irq_oe_next[irq_lvl[d]]  = 1'b1;
        irq_out_next[irq_lvl[d]] = irq_out_next[irq_lvl[d]] | irq_val[d];
      end
    end
  end

  // per device dma enable and channel
  logic [2:0] dma_en;
  logic [2:0] dma_req;
  logic [2:0] dma_ch [3];
  always_comb begin
    dma_ch[0]  = route_reg[LDRR_D_FDC].dma[2:0];
    dma_ch[1]  = route_reg[LDRR_D_PP].dma[2:0];
    dma_ch[2]  = route_reg[LDRR_D_U2].dma[2:0];
    dma_en[0]  = fdc_gate && !dma_ch[0][2];
    dma_en[1]  = act_reg[LDRR_A_PP] && pp_dma_gate && !dma_ch[1][2];
    dma_en[2]  = act_reg[LDRR_A_U2] && u2_dma_gate && !dma_ch[2][2];
    dma_req    = {U2_DRQ, PP_DRQ, FDC_DRQ};
  end

  logic [NDMA-1:0] drq_oe_next;
  logic [NDMA-1:0] drq_out_next;
  always_comb begin
    drq_oe_next  = '0;
    drq_out_next = '0;
    for (int d = 0; d < 3; d++) begin
      if (dma_en[d]) begin
        drq_oe_next[dma_ch[d][1:0]]  = 1'b1;
        drq_out_next[dma_ch[d][1:0]] = drq_out_next[dma_ch[d][1:0]] | dma_req[d];
      end
    end
  end

  // registered pin drivers and acknowledges
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      IRQ_OE   <= '0;
      IRQ_OUT  <= '0;
      DRQ_OE   <= '0;
      DRQ_OUT  <= '0;
      FDC_DACK <= 1'b0;
      PP_DACK  <= 1'b0;
      U2_DACK  <= 1'b0;
    end else begin
      IRQ_OE   <= irq_oe_next;
      IRQ_OUT  <= irq_out_next;
      DRQ_OE   <= drq_oe_next;
      DRQ_OUT  <= drq_out_next;
      FDC_DACK <= dma_en[0] && !ISA_DACK_N[dma_ch[0][1:0]];
      PP_DACK  <= dma_en[1] && !ISA_DACK_N[dma_ch[1][1:0]];
      U2_DACK  <= dma_en[2] && !ISA_DACK_N[dma_ch[2][1:0]];
    end
  end

  // base validity per device
  logic task_ok;
  logic misc_ok;
  logic twb_ok;
  logic pair_ok;
  assign task_ok = task_reg >= LDRR_TASK_MIN && task_reg <= LDRR_TASK_MAX
                   && task_reg[2:0] == 3'h0;
  assign misc_ok = misc_reg >= LDRR_MISC_MIN;
  assign twb_ok  = twb_reg <= LDRR_TWB_MAX && twb_reg[1:0] == 2'h0;
  assign pair_ok = pair_reg >= LDRR_PAIR_MIN && pair_reg <= LDRR_PAIR_MAX
                   && !pair_reg[0];

  // isa cycle qualifier, low twelve address bits only
  logic        cyc;
  logic [11:0] a;
  assign cyc = !ISA.aen && !(ISA.ior_n && ISA.iow_n);
  assign a   = ISA.addr[11:0];

  // registered chip selects; disks gated only by activate and base
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      KBD_DATA_SEL       <= 1'b0;
      KBD_CMD_SEL        <= 1'b0;
      GEN_RD_SEL         <= 1'b0;
      GEN_WR_SEL         <= 1'b0;
      TWB_SEL            <= 1'b0;
      TWB_REG            <= 2'h0;
      PAIR_INDEX_SEL     <= 1'b0;
      PAIR_DATA_SEL      <= 1'b0;
      DISK_TASK_SELECT_N <= 1'b1;
      DISK_TASK_REG      <= 3'h0;
      DISK_AUX_SELECT_N  <= 1'b1;
    end else begin
      KBD_DATA_SEL   <= cyc && act_reg[LDRR_A_KBD] && a == LDRR_KBD_DATA;
      KBD_CMD_SEL    <= cyc && act_reg[LDRR_A_KBD] && a == LDRR_KBD_CMD;
      GEN_RD_SEL     <= cyc && !ISA.ior_n && act_reg[LDRR_A_AUX] && a == grd_reg;
      GEN_WR_SEL     <= cyc && !ISA.iow_n && act_reg[LDRR_A_AUX] && a == gwr_reg;
      TWB_SEL        <= cyc && act_reg[LDRR_A_TWB] && twb_ok
                        && a[11:2] == twb_reg[11:2];
      TWB_REG        <= a[1:0];
      PAIR_INDEX_SEL <= cyc && act_reg[LDRR_A_PAIR] && pair_ok
                        && a == pair_reg;
      PAIR_DATA_SEL  <= cyc && act_reg[LDRR_A_PAIR] && pair_ok
                        && a == {pair_reg[11:1], 1'b1};
      DISK_TASK_SELECT_N <= !(cyc && act_reg[LDRR_A_DISK] && task_ok
                              && a[11:3] == task_reg[11:3]);
      DISK_TASK_REG      <= a[2:0];
      DISK_AUX_SELECT_N  <= !(cyc && act_reg[LDRR_A_DISK] && misc_ok
                              && a == misc_reg);
    end
  end

  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  sequence s_kbd_data;
    cyc && act_reg[LDRR_A_KBD] && ISA.addr[11:0] == LDRR_KBD_DATA;
  endsequence
  sequence s_apb_start;
    PSEL && !PENABLE;
  endsequence
  sequence s_apb_access;
    PSEL && PENABLE;
  endsequence

  AST_KBD_DATA: assert property (s_kbd_data |=> KBD_DATA_SEL)
    else $error("keyboard data select missed");
  AST_KBD_CMD: assert property (KBD_CMD_SEL |-> $past(a) == LDRR_KBD_CMD && $past(cyc))
    else $error("keyboard command select at wrong port");
  AST_IRQ_ZERO: assert property (!IRQ_OE[0])
    else $error("interrupt level zero driven");
  AST_IRQ_FLOAT: assert property (irq_en == 4'h0 |=> IRQ_OE == '0)
    else $error("irq pin driven with no device enabled");
  AST_DRQ_FLOAT: assert property (dma_en == 3'h0 |=> DRQ_OE == '0)
    else $error("dma request pin driven with no device enabled");
  AST_FDC_DOWN: assert property (gate_reg[LDRR_G_FPD] |=> !FDC_DACK)
    else $error("powered down floppy acknowledged dma");
  AST_U1_AUXB: assert property (!uart_reg[LDRR_U1_OUT] |-> !irq_en[LDRR_D_U1])
    else $error("uart interrupt enabled with aux output low");
  AST_DMA_NONE: assert property (route_reg[LDRR_D_FDC].dma[2] |-> !dma_en[0])
    else $error("dma select four or more enabled a channel");
  AST_TASK_BAD: assert property (!task_ok |=> DISK_TASK_SELECT_N)
    else $error("task select with invalid base");
  AST_AUX_ONE: assert property (!DISK_AUX_SELECT_N |-> $past(a) == $past(misc_reg))
    else $error("disk aux select off its single address");
  AST_APB_ANSWER: assert property (s_apb_start ##1 s_apb_access |-> ##1 PREADY)
    else $error("apb answer late");

endmodule

// >>> tb/ldrr_host_model.sv
// isa host side model: io cycles and dma acknowledges toward the routing block
`timescale 1ns/1ps
module ldrr_host_model
  import ldrr_pkg::*;
(
  input  wire logic       SYS_CLK,
  output ldrr_isa_t       ISA,
  output logic      [3:0] ISA_DACK_N
);
  // idle bus at time zero
  initial begin
    ISA        = '{addr: 16'hffff, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
    ISA_DACK_N = 4'hf;
  end

  // one io cycle, held across two edges so the registered selects settle
  task automatic io(input logic [15:0] a, input logic rd);
    @(posedge SYS_CLK);
    ISA <= '{addr: a, aen: 1'b0, ior_n: !rd, iow_n: rd};
    repeat (2) @(posedge SYS_CLK);
  endtask

  // end of cycle: address lines flip so no stale value lingers
  task automatic idle();
    @(posedge SYS_CLK);
    ISA <= '{addr: ~ISA.addr, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
  endtask

  // acknowledge pattern, active low, held until changed again
  task automatic dack(input logic [3:0] n);
    @(posedge SYS_CLK);
    ISA_DACK_N <= n;
    repeat (2) @(posedge SYS_CLK);
  endtask
endmodule

// >>> tb/ldrr_tb.sv
// bench for resource routing: apb set-up, isa decode, irq and dma gating
`timescale 1ns/1ps
module ldrr_tb;
  import ldrr_pkg::*;
  localparam logic [8:0] S_KD = 9'h100, S_KC = 9'h080, S_GR = 9'h040, S_GW = 9'h020;
  localparam logic [8:0] S_TW = 9'h010, S_PI = 9'h008, S_PD = 9'h004, S_DT = 9'h002;
  localparam logic [8:0] S_DA = 9'h001;
  logic        SYS_CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rdat;
  ldrr_isa_t   ISA;
  logic        FDC_IRQ, PP_IRQ, U1_IRQ, U2_IRQ, FDC_DRQ, PP_DRQ, U2_DRQ, rerr;
  logic [3:0]  ISA_DACK_N, DRQ_OUT, DRQ_OE;
  logic [15:0] IRQ_OUT, IRQ_OE;
  logic        FDC_DACK, PP_DACK, U2_DACK, KBD_DATA_SEL, KBD_CMD_SEL, GEN_RD_SEL, GEN_WR_SEL;
  logic        TWB_SEL, PAIR_INDEX_SEL, PAIR_DATA_SEL, DISK_TASK_SELECT_N, DISK_AUX_SELECT_N;
  logic [1:0]  TWB_REG;
  logic [2:0]  DISK_TASK_REG;
  logic [8:0]  sel;
  int          bad_count = 0;
  int          cmp_count = 0;

  // one bit per select, disk selects turned active high
  assign sel = {KBD_DATA_SEL, KBD_CMD_SEL, GEN_RD_SEL, GEN_WR_SEL, TWB_SEL, PAIR_INDEX_SEL,
                PAIR_DATA_SEL, ~DISK_TASK_SELECT_N, ~DISK_AUX_SELECT_N};

  ldrr_top DUT (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ISA(ISA), .FDC_IRQ(FDC_IRQ), .PP_IRQ(PP_IRQ), .U1_IRQ(U1_IRQ), .U2_IRQ(U2_IRQ),
    .FDC_DRQ(FDC_DRQ), .PP_DRQ(PP_DRQ), .U2_DRQ(U2_DRQ), .ISA_DACK_N(ISA_DACK_N),
    .IRQ_OUT(IRQ_OUT), .IRQ_OE(IRQ_OE), .DRQ_OUT(DRQ_OUT), .DRQ_OE(DRQ_OE),
    .FDC_DACK(FDC_DACK), .PP_DACK(PP_DACK), .U2_DACK(U2_DACK), .KBD_DATA_SEL(KBD_DATA_SEL),
    .KBD_CMD_SEL(KBD_CMD_SEL), .GEN_RD_SEL(GEN_RD_SEL), .GEN_WR_SEL(GEN_WR_SEL),
    .TWB_SEL(TWB_SEL),
    .TWB_REG(TWB_REG), .PAIR_INDEX_SEL(PAIR_INDEX_SEL), .PAIR_DATA_SEL(PAIR_DATA_SEL),
    .DISK_TASK_SELECT_N(DISK_TASK_SELECT_N), .DISK_TASK_REG(DISK_TASK_REG),
    .DISK_AUX_SELECT_N(DISK_AUX_SELECT_N)
  );
  ldrr_host_model host (.SYS_CLK(SYS_CLK), .ISA(ISA), .ISA_DACK_N(ISA_DACK_N));

  // 100 ns clock
  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end

  task automatic end_of_test();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // apb transfer: hold the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge SYS_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    n = 0;
    // answer taken at the rising edge, before that edge updates the flops
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1) begin
      bad_count++;
      $display("ERROR at %0t: no bus answer", $time);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
    chk({31'h0, rerr}, {31'h0, err});
  endtask

  // io cycle, then selects and the passed-through low address bits
  task automatic dec(input logic [15:0] a, input logic r, input logic [8:0] exp);
    host.io(a, r);
    #1;
    chk({23'h0, sel}, {23'h0, exp});
    chk({27'h0, TWB_REG, DISK_TASK_REG}, {27'h0, a[1:0], a[2:0]});
    host.idle();
  endtask

  // interrupt pins after a gate change: enables and driven-high lines
  task automatic rt(input logic [15:0] oe, input logic [15:0] hi);
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk({16'h0, IRQ_OE}, {16'h0, oe});
    chk({16'h0, IRQ_OUT & IRQ_OE}, {16'h0, hi});
  endtask

  task automatic dm(input logic [3:0] oe);
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk({28'h0, DRQ_OE}, {28'h0, oe});
    chk({28'h0, DRQ_OUT & DRQ_OE}, {28'h0, oe});
  endtask

  initial begin
    SRST = 1'b1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {FDC_IRQ, PP_IRQ, U1_IRQ, U2_IRQ, FDC_DRQ, PP_DRQ, U2_DRQ} = 7'h0;
    repeat (8) @(posedge SYS_CLK);
    SRST <= 1'b0;
    {FDC_IRQ, PP_IRQ, U1_IRQ, U2_IRQ, FDC_DRQ, PP_DRQ, U2_DRQ} <= 7'h7f;
    // reset values, then an unmapped place
    rd(LDRR_IRQ_OFS, 32'h00, 1'b0);
    rd(LDRR_DMA_OFS, 32'h04, 1'b0);
    rd(LDRR_STAT_OFS, 32'h0, 1'b0);
    rd(8'hfc, 32'h0, 1'b1);
    // power bits mirror into activate bits
    wr(LDRR_PWR_OFS, 32'h1e2);
    rd(LDRR_ACT_OFS, 32'h1e2, 1'b0);
    dec(16'hf060, 1'b1, S_KD);
    dec(16'h0064, 1'b1, S_KC);
    dec(16'h0062, 1'b1, 9'h0);
    wr(LDRR_GRD_OFS, 32'h005);
    wr(LDRR_GWR_OFS, 32'hfff);
    dec(16'h0005, 1'b1, S_GR);
    dec(16'h0005, 1'b0, 9'h0);
    dec(16'h0fff, 1'b0, S_GW);
    wr(LDRR_PAIR_OFS, 32'h100);
    dec(16'h0100, 1'b1, S_PI);
    dec(16'h0101, 1'b1, S_PD);
    wr(LDRR_PAIR_OFS, 32'h0f0);
    dec(16'h00f0, 1'b1, 9'h0);
    wr(LDRR_TWB_OFS, 32'hffc);
    for (int i = 0; i < 4; i++) begin
      dec(16'h0ffc + 16'(i), 1'b1, S_TW);
    end
    wr(LDRR_TASK_OFS, 32'h1f0);
    wr(LDRR_MISC_OFS, 32'h3f6);
    for (int i = 0; i < 9; i++) begin
      dec(16'h01f0 + 16'(i), 1'b1, i < 8 ? S_DT : 9'h0);
    end
    dec(16'h03f6, 1'b1, S_DA);
    dec(16'h03f7, 1'b1, 9'h0);
    wr(LDRR_ACT_OFS, 32'h0);
    rd(LDRR_PWR_OFS, 32'h0, 1'b0);
    dec(16'h0064, 1'b1, 9'h0);
    // floppy interrupt over every level
    wr(LDRR_ACT_OFS, 32'h1ff);
    wr(LDRR_LDN_OFS, {30'h0, LDRR_D_FDC});
    wr(LDRR_GATE_OFS, 32'h1);
    for (int n = 0; n < 16; n++) begin
      wr(LDRR_IRQ_OFS, {24'h0, 4'ha, n[3:0]});
      rd(LDRR_IRQ_OFS, {24'h0, 4'ha, n[3:0]}, 1'b0);
      rt(n == 0 ? 16'h0 : 16'h1 << n, n == 0 ? 16'h0 : 16'h1 << n);
    end
    @(posedge SYS_CLK);
    FDC_IRQ <= 1'b0;
    rt(16'h8000, 16'h0);
    wr(LDRR_GATE_OFS, 32'h0);
    rt(16'h0, 16'h0);
    wr(LDRR_GATE_OFS, 32'h3);
    rt(16'h0, 16'h0);
    wr(LDRR_GATE_OFS, 32'h1);
    wr(LDRR_ACT_OFS, 32'h1fe);
    rt(16'h0, 16'h0);
    // first serial port: enable bits and auxiliary output two
    wr(LDRR_LDN_OFS, {30'h0, LDRR_D_U1});
    wr(LDRR_IRQ_OFS, 32'h4);
    for (int i = 0; i < 4; i++) begin
      wr(LDRR_UART_OFS, i == 0 ? 32'h1f : i == 1 ? 32'h0f : i == 2 ? 32'h10 : 32'h18);
      rt(i == 0 || i == 3 ? 16'h0010 : 16'h0, i == 0 || i == 3 ? 16'h0010 : 16'h0);
    end
    wr(LDRR_UART_OFS, 32'h0);
    // parallel port: standard, enhanced, then every extended-control mode
    wr(LDRR_LDN_OFS, {30'h0, LDRR_D_PP});
    wr(LDRR_IRQ_OFS, 32'h7);
    wr(LDRR_GATE_OFS, 32'h004);
    rt(16'h0080, 16'h0080);
    wr(LDRR_GATE_OFS, 32'h000);
    rt(16'h0, 16'h0);
    wr(LDRR_GATE_OFS, 32'h00c);
    rt(16'h0080, 16'h0);
    wr(LDRR_GATE_OFS, 32'h008);
    rt(16'h0, 16'h0);
    for (int m = 0; m < 16; m++) begin
      wr(LDRR_GATE_OFS, {24'h0, m[3:1], 2'h2, m[0], 2'h0});
      rt(m[3:1] inside {3'h2, 3'h3, 3'h6} || m[0] ? 16'h0080 : 16'h0, 16'h0);
    end
    wr(LDRR_GATE_OFS, 32'h174);
    rt(16'h0, 16'h0);
    // floppy dma over every channel code, with acknowledge
    wr(LDRR_ACT_OFS, 32'h1ff);
    wr(LDRR_LDN_OFS, {30'h0, LDRR_D_FDC});
    wr(LDRR_GATE_OFS, 32'h1);
    for (int c = 0; c < 8; c++) begin
      wr(LDRR_DMA_OFS, c);
      dm(c < 4 ? 4'h1 << c : 4'h0);
    end
    wr(LDRR_DMA_OFS, 32'h2);
    host.dack(4'hb);
    #1;
    chk({31'h0, FDC_DACK}, 32'h1);
    wr(LDRR_GATE_OFS, 32'h0);
    dm(4'h0);
    chk({31'h0, FDC_DACK}, 32'h0);
    host.dack(4'hf);
    // extended parallel and second serial port dma gates
    wr(LDRR_LDN_OFS, {30'h0, LDRR_D_PP});
    wr(LDRR_DMA_OFS, 32'h1);
    wr(LDRR_GATE_OFS, 32'h210);
    dm(4'h2);
    host.dack(4'hd);
    #1;
    chk({31'h0, PP_DACK}, 32'h1);
    host.dack(4'hf);
    wr(LDRR_GATE_OFS, 32'h010);
    dm(4'h0);
    wr(LDRR_LDN_OFS, {30'h0, LDRR_D_U2});
    wr(LDRR_DMA_OFS, 32'h3);
    wr(LDRR_UART_OFS, 32'h2000);
    dm(4'h8);
    host.dack(4'h7);
    #1;
    chk({31'h0, U2_DACK}, 32'h1);
    chk({31'h0, PP_DACK}, 32'h0);
    end_of_test();
  end
endmodule
